// >>> clock_control_params.svh
`ifndef CLOCK_CONTROL_PARAMS_SVH
`define CLOCK_CONTROL_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_PLL_CLOCK_CONFIG     16'hfc33
`define IDX_CLOCK_OUTPUT_DIVIDER 16'hfc3f
`define IDX_LSB                  2
`define IDX_MSB                  17

`define RST_PLL_CLOCK_CONFIG     16'h0000
`define RST_CLOCK_OUTPUT_DIVIDER 16'h0000

// pll_clock_config fields
`define MULT_MSB                 3
`define MULT_LSB                 0
`define BIT_PLL_INPUT_HALVE      4
`define BIT_OUTPUT_CLOCK_SWITCH  5
`define BIT_USB_CLOCK_MODE       6
`define BIT_CLOCK_OUTPUT_ENABLE  7
`define BIT_LOCK_CHECK_START     8
`define BIT_GLOBAL_DIVIDE_BY_2   9
`define BIT_GLOBAL_DIVIDE_BY_256 10
`define BIT_LOCK_STATUS          11
`define BIT_RTC_SLEEP_ENABLE     12
`define BIT_USB_CLOCK_GATE       13
`define BIT_STORAGE_CLOCK_GATE   14
`define BIT_SPDIF_CLOCK_GATE     15

// clock_output_divider fields
`define ODIV_MSB                 2
`define ODIV_LSB                 0
`define BIT_OUTPUT_CLOCK_POLARITY 3

// global divider counter taps
`define GCNT_TAP_DIV2            0
`define GCNT_TAP_DIV256          7
`define GCNT_TAP_DIV512          8

`define HTRANS_NONSEQ            2'b10
`define HTRANS_SEQ               2'b11

`endif

// >>> clock_control_pkg.sv
package clock_control_pkg;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
    } ahb_request_type;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } ahb_response_type;

    typedef struct packed {
        logic pll_enable;
        logic [3:0] pll_multiplier;
        logic pll_reference;
    } pll_control_type;

    typedef struct packed {
        logic global_clock;
        logic crystal_domain_clock;
        logic storage_clock;
        logic spdif_clock;
        logic usb_clock;
    } peripheral_clocks_type;

endpackage

// >>> clock_pad_driver.sv
`include "clock_control_params.svh"

// glitch-free two-input clock switch: a source is released only while it is
// low and the other is taken only once the first is fully released
module clock_pad_driver (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    // sources
    input  wire logic select_primary_i,
    input  wire logic primary_clock_i,
    input  wire logic secondary_clock_i,
    // result
    output logic      pad_clock_o
);

    logic en_primary_r;
    logic en_primary_nxt;
    logic en_secondary_r;
    logic en_secondary_nxt;
    logic pad_clock_r;
    logic pad_clock_nxt;

    always_comb begin
        en_primary_nxt   = en_primary_r;
        en_secondary_nxt = en_secondary_r;
        if (!primary_clock_i) begin
            en_primary_nxt = select_primary_i && !en_secondary_r;
        end
        if (!secondary_clock_i) begin
            en_secondary_nxt = !select_primary_i && !en_primary_r;
        end
        pad_clock_nxt = (primary_clock_i && en_primary_r) ||
                        (secondary_clock_i && en_secondary_r);
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            en_primary_r   <= 1'b0;
            en_secondary_r <= 1'b0;
            pad_clock_r    <= 1'b0;
        end else begin
            en_primary_r   <= en_primary_nxt;
            en_secondary_r <= en_secondary_nxt;
            pad_clock_r    <= pad_clock_nxt;
        end
    end

    assign pad_clock_o = pad_clock_r;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    AST_PAD_NO_OVERLAP: assert property (
        !(en_primary_r && en_secondary_r))
        else $error("both pad clock sources enabled");

endmodule

// >>> clock_partner_model.sv
// analog side of the clock block: crystal, pll oscillator, usb transceiver
// clock and the pll lock indicator
module clock_partner_model #(
    parameter int LOCK_DELAY = 16
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    // lock request from the bench
    input  wire logic lock_request_i,
    // clock sources and lock indicator
    output logic      crystal_o,
    output logic      pll_osc_o,
    output logic      usb_o,
    output logic      locked_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [4:0] phase_r;
    int         lock_cnt;

    // sources kept slow enough for the two-flop samplers of the block
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            phase_r <= '0;
            crystal_o <= 1'b0;
            pll_osc_o <= 1'b0;
            usb_o <= 1'b0;
        end else begin
            phase_r <= (phase_r == 5'd23) ? 5'd0 : phase_r + 5'd1;
            if (phase_r % 4 == 3) crystal_o <= ~crystal_o;
            if (phase_r % 2 == 1) pll_osc_o <= ~pll_osc_o;
            if (phase_r % 3 == 2) usb_o <= ~usb_o;
        end
    end

    // lock is acquired slowly and lost at once
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !lock_request_i) begin
            lock_cnt <= 0;
        end else if (lock_cnt < LOCK_DELAY) begin
            lock_cnt <= lock_cnt + 1;
        end
    end
    assign locked_o = (lock_cnt == LOCK_DELAY);
endmodule

// >>> pll_clock_control.sv
// The implementer's own choice: the AHB-Lite register port.
`include "clock_control_params.svh"

module pll_clock_control
    import clock_control_pkg::*;
#(
    parameter int SYNC_WIDTH = 4
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             reset_i,
    // ahb-lite slave
    input  wire ahb_request_type  ahb_req_i,
    input  wire logic [31:0]      hwdata_i,
    output ahb_response_type      ahb_rsp_o,
    // analog and clock pins
    input  wire logic             crystal_oscillator_input_i,
    input  wire logic             usb_transceiver_clock_i,
    input  wire logic             pll_vco_clock_i,
    input  wire logic             pll_locked_i,
    // other pad clock sources and pad mode
    input  wire logic             port0_pin2_peripheral_mode_i,
    input  wire logic             converter_clock_enable_i,
    input  wire logic             converter_clock_i,
    input  wire logic             audio_master_clock_enable_i,
    input  wire logic             audio_master_clock_i,
    // pll and clock outputs
    output pll_control_type       pll_control_o,
    output peripheral_clocks_type periph_clocks_o,
    output logic                  core_clock_o,
    output logic                  rtc_sleep_enable_o,
    // pad
    output logic                  port0_pin2_clock_pad_o,
    output logic                  port0_pin2_clock_pad_oe_n_o
);

    // ---------------------------------------------------------------- sync
    logic [SYNC_WIDTH-1:0] pins;
    logic [SYNC_WIDTH-1:0] sync1_r;
    logic [SYNC_WIDTH-1:0] sync2_r;
    logic xtal_s;
    logic usb_s;
    logic vco_s;
    logic lock_s;

    assign pins = {pll_locked_i, pll_vco_clock_i, usb_transceiver_clock_i,
                   crystal_oscillator_input_i};

    for (genvar i = 0; i < SYNC_WIDTH; i++) begin : g_sync
        always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
                sync1_r[i] <= 1'b0;
                sync2_r[i] <= 1'b0;
            end else begin
                sync1_r[i] <= pins[i];
                sync2_r[i] <= sync1_r[i];
            end
        end
    end

    assign xtal_s = sync2_r[0];
    assign usb_s  = sync2_r[1];
    assign vco_s  = sync2_r[2];
    assign lock_s = sync2_r[3];

    // ----------------------------------------------------------- registers
    logic [15:0] cf_r;
    logic [15:0] cf_nxt;
    logic [15:0] div_r;
    logic [15:0] div_nxt;
    logic        lock_status_r;
    logic        lock_status_nxt;
    logic        wr_pend_r;
    logic        wr_pend_nxt;
    logic [15:0] wr_idx_r;
    logic [15:0] wr_idx_nxt;
    ahb_response_type rsp_r;
    ahb_response_type rsp_nxt;
    logic        addr_phase;
    logic [15:0] req_idx;
    logic [15:0] cf_view;

    assign addr_phase = ahb_req_i.hsel && ahb_req_i.hready &&
                        (ahb_req_i.htrans == `HTRANS_NONSEQ ||
                         ahb_req_i.htrans == `HTRANS_SEQ);
    assign req_idx = ahb_req_i.haddr[`IDX_MSB:`IDX_LSB];

    always_comb begin
        cf_view = cf_r;
        cf_view[`BIT_LOCK_STATUS] = lock_status_r;
    end

    always_comb begin
        cf_nxt      = cf_r;
        div_nxt     = div_r;
        wr_pend_nxt = addr_phase && ahb_req_i.hwrite;
        wr_idx_nxt  = addr_phase ? req_idx : wr_idx_r;
        rsp_nxt     = rsp_r;
        rsp_nxt.hreadyout = 1'b1;
        rsp_nxt.hresp     = 1'b0;
        if (wr_pend_r && wr_idx_r == `IDX_PLL_CLOCK_CONFIG) begin
            cf_nxt = hwdata_i[15:0];
        end
        if (wr_pend_r && wr_idx_r == `IDX_CLOCK_OUTPUT_DIVIDER) begin
            div_nxt = {12'h000, hwdata_i[3:0]};
        end
        if (addr_phase && !ahb_req_i.hwrite) begin
            if (req_idx == wr_idx_r && wr_pend_r) begin
                rsp_nxt.hrdata = {16'h0000, hwdata_i[15:0]};
                if (req_idx == `IDX_PLL_CLOCK_CONFIG) begin
                    rsp_nxt.hrdata[`BIT_LOCK_STATUS] = lock_status_r;
                end else if (req_idx == `IDX_CLOCK_OUTPUT_DIVIDER) begin
                    rsp_nxt.hrdata = {28'h0000000, hwdata_i[3:0]};
                end else begin
                    rsp_nxt.hrdata = 32'h00000000;
                end
            end else if (req_idx == `IDX_PLL_CLOCK_CONFIG) begin
                rsp_nxt.hrdata = {16'h0000, cf_view};
            end else if (req_idx == `IDX_CLOCK_OUTPUT_DIVIDER) begin
                rsp_nxt.hrdata = {16'h0000, div_r};
            end else begin
                rsp_nxt.hrdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cf_r      <= `RST_PLL_CLOCK_CONFIG;
            div_r     <= `RST_CLOCK_OUTPUT_DIVIDER;
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 16'h0000;
            // ready already high in reset, so the bus never sees a stall
            rsp_r     <= '{32'h00000000, 1'b1, 1'b0};
        end else begin
            cf_r      <= cf_nxt;
            div_r     <= div_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_idx_r  <= wr_idx_nxt;
            rsp_r     <= rsp_nxt;
        end
    end

    assign ahb_rsp_o = rsp_r;

    // ---------------------------------------------------------- lock check
    logic chk_prev_r;
    logic chk_prev_nxt;

    always_comb begin
        chk_prev_nxt    = cf_r[`BIT_LOCK_CHECK_START];
        lock_status_nxt = lock_status_r && lock_s;
        if (chk_prev_r && !cf_r[`BIT_LOCK_CHECK_START]) begin
            lock_status_nxt = lock_s;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            chk_prev_r    <= 1'b0;
            lock_status_r <= 1'b0;
        end else begin
            chk_prev_r    <= chk_prev_nxt;
            lock_status_r <= lock_status_nxt;
        end
    end

    // ------------------------------------------------------- clock network
    logic       xtal_prev_r;
    logic       core_prev_r;
    logic       xtal_half_r;
    logic       xtal_half_nxt;
    logic [8:0] gcnt_r;
    logic [8:0] gcnt_nxt;
    logic [8:0] xcnt_r;
    logic [8:0] xcnt_nxt;
    logic [2:0] ocnt_r;
    logic [2:0] ocnt_nxt;
    logic       core_src;
    logic       odiv_clk;
    logic [2:0] odiv;
    pll_control_type       pll_r;
    pll_control_type       pll_nxt;
    peripheral_clocks_type clk_r;
    peripheral_clocks_type clk_nxt;
    logic core_r;
    logic rtc_r;
    logic pad_src_r;
    logic pad_src_nxt;
    logic oe_n_r;
    logic oe_n_nxt;
    logic other_clk;

    function automatic logic global_pick(input logic [8:0] cnt,
                                         input logic       base,
                                         input logic       d2,
                                         input logic       d256);
        logic r;
        r = base;
        if (d2 && d256) begin
            r = cnt[`GCNT_TAP_DIV512];
        end else if (d256) begin
            r = cnt[`GCNT_TAP_DIV256];
        end else if (d2) begin
            r = cnt[`GCNT_TAP_DIV2];
        end
        return r;
    endfunction

    assign odiv = div_r[`ODIV_MSB:`ODIV_LSB];

    always_comb begin
        core_src = xtal_s;
        if (cf_r[`BIT_OUTPUT_CLOCK_SWITCH]) begin
            core_src = cf_r[`BIT_USB_CLOCK_MODE] ? usb_s : vco_s;
        end
        xtal_half_nxt = (xtal_s && !xtal_prev_r) ? !xtal_half_r : xtal_half_r;
        gcnt_nxt = (core_src && !core_prev_r) ? gcnt_r + 9'h001 : gcnt_r;
        xcnt_nxt = (xtal_s && !xtal_prev_r) ? xcnt_r + 9'h001 : xcnt_r;
        ocnt_nxt = ocnt_r;
        // a count left above a lowered limit restarts at once
        if (ocnt_r > odiv) begin
            ocnt_nxt = 3'h0;
        end else if (core_src && !core_prev_r) begin
            ocnt_nxt = (ocnt_r >= odiv) ? 3'h0 : ocnt_r + 3'h1;
        end
        odiv_clk = (odiv == 3'h0) ? core_src :
                   ({1'b0, ocnt_r} < ({1'b0, odiv} + 4'h1) >> 1);
        pad_src_nxt = odiv_clk ^ div_r[`BIT_OUTPUT_CLOCK_POLARITY];

        pll_nxt.pll_multiplier = cf_r[`MULT_MSB:`MULT_LSB];
        pll_nxt.pll_enable     = cf_r[`MULT_MSB:`MULT_LSB] != 4'h0;
        pll_nxt.pll_reference  = cf_r[`BIT_PLL_INPUT_HALVE] ?
                                 xtal_half_r : xtal_s;

        clk_nxt.global_clock = global_pick(gcnt_r, core_src,
                                           cf_r[`BIT_GLOBAL_DIVIDE_BY_2],
                                           cf_r[`BIT_GLOBAL_DIVIDE_BY_256]);
        clk_nxt.crystal_domain_clock = global_pick(xcnt_r, xtal_s,
                                           cf_r[`BIT_GLOBAL_DIVIDE_BY_2],
                                           cf_r[`BIT_GLOBAL_DIVIDE_BY_256]);
        clk_nxt.storage_clock = clk_nxt.global_clock &&
                                !cf_r[`BIT_STORAGE_CLOCK_GATE];
        clk_nxt.spdif_clock   = clk_nxt.global_clock &&
                                !cf_r[`BIT_SPDIF_CLOCK_GATE];
        clk_nxt.usb_clock     = clk_nxt.global_clock &&
                                !cf_r[`BIT_USB_CLOCK_GATE];

        oe_n_nxt = !(port0_pin2_peripheral_mode_i &&
                     (cf_r[`BIT_CLOCK_OUTPUT_ENABLE] ||
                      converter_clock_enable_i ||
                      audio_master_clock_enable_i));
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            xtal_prev_r <= 1'b0;
            core_prev_r <= 1'b0;
            xtal_half_r <= 1'b0;
            gcnt_r      <= 9'h000;
            xcnt_r      <= 9'h000;
            ocnt_r      <= 3'h0;
            pll_r       <= '0;
            clk_r       <= '0;
            core_r      <= 1'b0;
            rtc_r       <= 1'b0;
            pad_src_r   <= 1'b0;
            oe_n_r      <= 1'b1;
        end else begin
            xtal_prev_r <= xtal_s;
            core_prev_r <= core_src;
            xtal_half_r <= xtal_half_nxt;
            gcnt_r      <= gcnt_nxt;
            xcnt_r      <= xcnt_nxt;
            ocnt_r      <= ocnt_nxt;
            pll_r       <= pll_nxt;
            clk_r       <= clk_nxt;
            core_r      <= core_src;
            rtc_r       <= cf_r[`BIT_RTC_SLEEP_ENABLE];
            pad_src_r   <= pad_src_nxt;
            oe_n_r      <= oe_n_nxt;
        end
    end

    // converter clock outranks the audio master clock on the shared pad
    assign other_clk = converter_clock_enable_i ? converter_clock_i
                                                : audio_master_clock_i;

    clock_pad_driver u_pad (
        .ref_clk_i         (ref_clk_i),
        .reset_i           (reset_i),
        .select_primary_i  (cf_r[`BIT_CLOCK_OUTPUT_ENABLE]),
        .primary_clock_i   (pad_src_r),
        .secondary_clock_i (other_clk),
        .pad_clock_o       (port0_pin2_clock_pad_o)
    );

    assign pll_control_o               = pll_r;
    assign periph_clocks_o             = clk_r;
    assign core_clock_o                = core_r;
    assign rtc_sleep_enable_o          = rtc_r;
    assign port0_pin2_clock_pad_oe_n_o = oe_n_r;

    // ---------------------------------------------------------- assertions
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    AST_PLL_ENABLE: assert property (
        pll_control_o.pll_enable == ($past(cf_r[3:0]) != 4'h0))
        else $error("pll enable does not follow multiplier");
    AST_PLL_REF: assert property (
        !$past(cf_r[4]) |-> pll_control_o.pll_reference == $past(xtal_s))
        else $error("pll reference not crystal");
    AST_CORE_XTAL: assert property (
        !$past(cf_r[5]) |-> core_clock_o == $past(xtal_s))
        else $error("core clock not crystal");
    AST_CORE_USB: assert property (
        $past(cf_r[5]) && $past(cf_r[6]) |-> core_clock_o == $past(usb_s))
        else $error("core clock not usb clock");
    AST_PAD_OE: assert property (
        cf_r[7] && port0_pin2_peripheral_mode_i |=> !oe_n_r)
        else $error("pad not driven");
    AST_LOCK_HOLD: assert property (
        lock_status_r && !lock_s && !(chk_prev_r && !cf_r[8]) |=>
        !lock_status_r)
        else $error("lock status held without lock");
    AST_DIV2: assert property (
        $rose(gcnt_r[0]) |-> $past(core_src) && !$past(core_prev_r))
        else $error("divider counted without rising edge");
    AST_RTC: assert property (
        $rose(cf_r[12]) |=> rtc_sleep_enable_o)
        else $error("rtc sleep not applied");
    AST_GATE_STORAGE: assert property (
        cf_r[14] |=> !periph_clocks_o.storage_clock)
        else $error("storage clock not gated");
    AST_GATE_SPDIF: assert property (
        cf_r[15] |=> !periph_clocks_o.spdif_clock)
        else $error("spdif clock not gated");
    AST_GATE_USB: assert property (
        cf_r[13] |=> !periph_clocks_o.usb_clock)
        else $error("usb clock not gated");
    AST_ODIV_WRAP: assert property (
        ocnt_r <= odiv || $changed(div_r))
        else $error("output divider count past limit");
    AST_OKAY: assert property (
        ahb_rsp_o.hreadyout && !ahb_rsp_o.hresp)
        else $error("slave not ready or not okay");

endmodule

// >>> testbench.sv
`include "clock_control_params.svh"

module testbench import clock_control_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] CONFIG_ADDR =
        {14'h0, `IDX_PLL_CLOCK_CONFIG, 2'b00};
    localparam logic [31:0] ODIV_ADDR   =
        {14'h0, `IDX_CLOCK_OUTPUT_DIVIDER, 2'b00};
    localparam logic [31:0] BAD_ADDR    = 32'h0003f100;

    logic                  ref_clk;
    logic                  reset;
    logic                  hsel;
    logic [31:0]           haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [31:0]           hwdata;
    logic                  lock_request;
    logic                  periph_mode;
    logic                  conv_en;
    logic                  conv_clk;
    logic                  audio_en;
    logic                  crystal;
    logic                  pll_osc;
    logic                  usb;
    logic                  locked;
    ahb_request_type       req;
    ahb_response_type      rsp;
    pll_control_type       pll_ctl;
    peripheral_clocks_type clks;
    logic                  core_clk;
    logic                  rtc_sleep;
    logic                  pad;
    logic                  pad_oe_n;
    logic                  clr;
    logic                  win;
    logic [7:0]            taps;
    logic [7:0]            prev;
    logic [31:0]           edges [8];
    logic [31:0]           pad_high;
    logic [31:0]           rdata;
    int                    failures;
    int                    comparisons;

    assign req = '{hsel, haddr, htrans, hwrite, 3'b010, rsp.hreadyout};
    assign taps = {pll_ctl.pll_reference, pad, clks.usb_clock,
                   clks.spdif_clock, clks.storage_clock,
                   clks.crystal_domain_clock, clks.global_clock, core_clk};

    pll_clock_control i_pll_clock_control (
        .ref_clk_i                    (ref_clk),
        .reset_i                      (reset),
        .ahb_req_i                    (req),
        .hwdata_i                     (hwdata),
        .ahb_rsp_o                    (rsp),
        .crystal_oscillator_input_i   (crystal),
        .usb_transceiver_clock_i      (usb),
        .pll_vco_clock_i              (pll_osc),
        .pll_locked_i                 (locked),
        .port0_pin2_peripheral_mode_i (periph_mode),
        .converter_clock_enable_i     (conv_en),
        .converter_clock_i            (conv_clk),
        .audio_master_clock_enable_i  (audio_en),
        .audio_master_clock_i         (1'b0),
        .pll_control_o                (pll_ctl),
        .periph_clocks_o              (clks),
        .core_clock_o                 (core_clk),
        .rtc_sleep_enable_o           (rtc_sleep),
        .port0_pin2_clock_pad_o       (pad),
        .port0_pin2_clock_pad_oe_n_o  (pad_oe_n)
    );

    clock_partner_model i_clock_partner_model (
        .ref_clk_i      (ref_clk),
        .reset_i        (reset),
        .lock_request_i (lock_request),
        .crystal_o      (crystal),
        .pll_osc_o      (pll_osc),
        .usb_o          (usb),
        .locked_o       (locked)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // rising-edge and high-time counters over a measuring window
    always @(posedge ref_clk) begin
        prev <= taps;
        if (clr) begin
            for (int i = 0; i < 8; i++) edges[i] <= '0;
            pad_high <= '0;
        end else if (win) begin
            for (int i = 0; i < 8; i++) begin
                edges[i] <= edges[i] + 32'(taps[i] & ~prev[i]);
            end
            pad_high <= pad_high + 32'(pad);
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic bus_cycle(input logic [31:0] a, input logic wr,
                             input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= `HTRANS_NONSEQ;
        do @(posedge ref_clk); while (rsp.hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (rsp.hreadyout !== 1'b1);
        rdata = rsp.hrdata;
    endtask

    task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
        bus_cycle(a, 1'b1, d);
    endtask

    task automatic read_check(input logic [31:0] a, input logic [31:0] exp,
                              input string name);
        bus_cycle(a, 1'b0, 32'h0);
        check(name, rdata, exp);
    endtask

    task automatic measure(input int settle, input int n);
        repeat (settle) @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        win <= 1'b1;
        repeat (n) @(posedge ref_clk);
        win <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic test_registers();
        read_check(CONFIG_ADDR, 32'h0, "config reset");
        read_check(ODIV_ADDR, 32'h0, "divider reset");
        bus_write(BAD_ADDR, 32'hffffffff);
        read_check(BAD_ADDR, 32'h0, "unmapped");
        bus_write(ODIV_ADDR, 32'hffffffff);
        read_check(ODIV_ADDR, 32'h0000000f, "divider bits");
        read_check(CONFIG_ADDR, 32'h0, "config apart");
        bus_write(ODIV_ADDR, 32'h0);
        check("oe idle", pad_oe_n, 32'h1);
    endtask

    task automatic test_multiplier();
        logic [7:0] cfg [3] = '{8'h00, 8'h01, 8'h1f};
        for (int i = 0; i < 3; i++) begin
            bus_write(CONFIG_ADDR, {24'h0, cfg[i]});
            measure(16, 240);
            read_check(CONFIG_ADDR, {24'h0, cfg[i]},
                       "config mult");
            check("mult", pll_ctl.pll_multiplier, cfg[i][3:0]);
            check("pll on", pll_ctl.pll_enable, cfg[i][3:0] != 0);
            if (cfg[i][3:0] != 4'h0) begin
                check("ref", edges[7], cfg[i][4] ? 15 : 30);
            end
        end
    endtask

    task automatic test_lock_switch();
        bus_write(CONFIG_ADDR, 32'h0100);
        bus_write(CONFIG_ADDR, 32'h0000);
        repeat (6) @(posedge ref_clk);
        read_check(CONFIG_ADDR, 32'h0, "unlocked");
        lock_request <= 1'b1;
        bus_write(CONFIG_ADDR, 32'h0801);
        repeat (30) @(posedge ref_clk);
        read_check(CONFIG_ADDR, 32'h0001, "status write");
        bus_write(CONFIG_ADDR, 32'h0101);
        bus_write(CONFIG_ADDR, 32'h0001);
        repeat (6) @(posedge ref_clk);
        read_check(CONFIG_ADDR, 32'h0801, "locked");
        bus_write(CONFIG_ADDR, 32'h0021);
        measure(16, 240);
        check("pll core", edges[0], 60);
        bus_write(CONFIG_ADDR, 32'h0001);
        bus_write(CONFIG_ADDR, 32'h0041);
        bus_write(CONFIG_ADDR, 32'h0061);
        measure(16, 240);
        check("usb core", edges[0], 40);
        bus_write(CONFIG_ADDR, 32'h0041);
        measure(16, 240);
        check("crystal core", edges[0], 30);
        lock_request <= 1'b0;
        repeat (6) @(posedge ref_clk);
        read_check(CONFIG_ADDR, 32'h0041, "lock lost");
        bus_write(CONFIG_ADDR, 32'h0);
    endtask

    task automatic test_global();
        int shift [4] = '{0, 1, 8, 9};
        for (int i = 0; i < 4; i++) begin
            bus_write(CONFIG_ADDR, 32'(i) << 9);
            measure(4200, 4096);
            check("global", edges[1], 32'd512 >> shift[i]);
            check("crystal dom", edges[2], 32'd512 >> shift[i]);
        end
    endtask

    task automatic test_gates();
        for (int b = 12; b < 16; b++) begin
            bus_write(CONFIG_ADDR, 32'h1 << b);
            measure(16, 240);
            check("rtc", rtc_sleep, b == 12);
            check("storage", edges[3], (b == 14) ? 0 : 30);
            check("spdif", edges[4], (b == 15) ? 0 : 30);
            check("usb clk", edges[5], (b == 13) ? 0 : 30);
        end
        bus_write(CONFIG_ADDR, 32'h0);
    endtask

    task automatic test_pad();
        periph_mode <= 1'b1;
        conv_en <= 1'b1;
        audio_en <= 1'b1;
        measure(8, 8);
        check("converter pad", pad, 32'h1);
        check("oe on", pad_oe_n, 32'h0);
        conv_en <= 1'b0;
        measure(8, 8);
        check("audio pad", pad, 32'h0);
        // converter stays enabled but low, so the switch can hand over
        conv_en <= 1'b1;
        conv_clk <= 1'b0;
        bus_write(ODIV_ADDR, 32'h2);
        bus_write(CONFIG_ADDR, 32'h0080);
        measure(48, 240);
        check("pad div", edges[6], 10);
        check("pad duty", pad_high, 80);
        bus_write(ODIV_ADDR, 32'ha);
        measure(48, 240);
        check("pad polarity", pad_high, 160);
        bus_write(ODIV_ADDR, 32'h0);
        measure(48, 240);
        check("pad undivided", edges[6], 30);
        periph_mode <= 1'b0;
        measure(8, 8);
        check("oe off", pad_oe_n, 32'h1);
    endtask

    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = '0;
        lock_request = 1'b0;
        periph_mode = 1'b0;
        conv_en = 1'b0;
        conv_clk = 1'b1;
        audio_en = 1'b0;
        clr = 1'b0;
        win = 1'b0;
        failures = 0;
        comparisons = 0;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        test_registers();
        test_multiplier();
        test_lock_switch();
        test_gates();
        test_global();
        test_pad();
        final_report();
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        final_report();
    end
endmodule
